//--- rtl/phy_regs_map.vh
// Purpose: register map of the interrupt, crossover and control/status bank
// Assumes: clause-22 style 5-bit register addresses, 16-bit data
// Notes:   all offsets, fields, resets and frame constants as macros
`ifndef PHY_REGS_MAP_VH
`define PHY_REGS_MAP_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_INT_CTRL_STAT  5'h1B
`define ADDR_XOVER_CTRL     5'h1C
`define ADDR_PHY_CTRL_STAT  5'h1F

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define INT_EN_MSB          15
`define INT_EN_LSB          8
`define XOVER_SWAP_OFF_BIT  6
`define XOVER_WIRING_BIT    7
`define CTRL_INT_LEVEL_BIT  14
`define CTRL_JABBER_EN_BIT  9
`define STAT_SPEED_1000_BIT 6
`define STAT_SPEED_100_BIT  5
`define STAT_SPEED_10_BIT   4
`define STAT_DUPLEX_BIT     3
`define STAT_MASTER_BIT     2
`define STAT_LINK_FAIL_BIT  0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_INT_CTRL_STAT   16'h0000
`define RST_XOVER_CTRL      16'h0000
`define RST_PHY_CTRL        16'h0200
// writable bits of the control register (15,14,13:12,9,8:7,1)
`define PHY_CTRL_RW_MASK    16'hF382

// ------------------------------------------------------------
// management frame
// ------------------------------------------------------------
`define MDIO_PHY_ADDR       5'h01
`define MDIO_OP_WRITE       2'h1
`define MDIO_OP_READ        2'h2
`define MDIO_PRE_BITS       6'h20

`endif

//--- rtl/mdio_sync.v
// Purpose: two-flop synchroniser and edge finder for the management pins
// Assumes: mdc slow against clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module mdio_sync (
  input  wire clk,
  input  wire nrst,
  input  wire mdc,
  input  wire mdio_i,
  output reg  mdc_rise,
  output reg  mdc_fall,
  output reg  mdio_s
);

  reg [1:0] mdc_meta_q;
  reg [1:0] mdio_meta_q;
  reg       mdc_last_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdc_meta_q  <= 2'h0;
      mdio_meta_q <= 2'h3;
      mdc_last_q  <= 1'b0;
      mdc_rise    <= 1'b0;
      mdc_fall    <= 1'b0;
      mdio_s      <= 1'b1;
    end else begin
      mdc_meta_q  <= {mdc_meta_q[0], mdc};
      mdio_meta_q <= {mdio_meta_q[0], mdio_i};
      mdc_last_q  <= mdc_meta_q[1];
      mdc_rise    <= mdc_meta_q[1] & ~mdc_last_q;
      mdc_fall    <= ~mdc_meta_q[1] & mdc_last_q;
      mdio_s      <= mdio_meta_q[1];
    end
  end

endmodule

//--- rtl/phy_irq_mdix_status_regs.v
// Purpose: interrupt, crossover and control/status registers behind MDC/MDIO
// Assumes: phy core events are one-cycle pulses on clk; status inputs are levels
// Notes:   clause-22 frames; read data shifted out on mdc falling edges
//
// Contract
// R01 - interrupt enable bit 9 gates remote fault event; resets zero
// R02 - interrupt enable bit 8 gates link-up event; resets zero
// R03 - enable bits 15..10 for jabber through link-down, read-write, reset zero
// R04 - status bit 7 sets on jabber, clears on register read
// R05 - status bit 6 sets on receive error, clears on read
// R06 - status bit 5 sets on page received, clears on read
// R07 - status bit 4 sets on parallel detect fault, clears on read
// R08 - status bit 3 sets on partner acknowledge, clears on read
// R09 - status bit 2 sets on link down, clears on read
// R10 - status bit 1 sets on remote fault, clears on read
// R11 - status bit 0 sets on link up, clears on read; all reset zero
// R12 - crossover bit 6 one disables automatic crossover; reset zero
// R13 - with auto off, bit 7 one selects MDI, zero MDI-X
// R14 - bit 7 ignored while automatic crossover is enabled
// R15 - control bit 14 sets interrupt pin polarity; zero means active low
// R16 - control bit 9 enables jabber counter; resets to one
// R17 - status bit 6 reads one at resolved 1000BASE-T
// R18 - status bit 5 reads one at resolved 100BASE-TX
// R19 - status bit 4 reads one at resolved 10BASE-T
// R20 - status bit 3 shows duplex, one full
// R21 - status bit 2 shows gigabit master one, slave zero
// R22 - status bit 0 reads one while link check fails
// R23 - interrupt asserted while any enabled status bit set
`timescale 1ns/1ps
`include "phy_regs_map.vh"
module phy_irq_mdix_status_regs (
  input  wire       clk,
  input  wire       nrst,
  input  wire       mdc,
  input  wire       mdio_i,
  output reg        mdio_o,
  output reg        mdio_oe,
  input  wire [7:0] event_pulse,
  input  wire       auto_mdix_pair,
  input  wire       speed_1000,
  input  wire       speed_100,
  input  wire       speed_10,
  input  wire       full_duplex,
  input  wire       gig_master,
  input  wire       link_check_fail,
  output reg        use_mdi,
  output reg        jabber_count_en,
  output reg        int_pin
);

  // ------------------------------------------------------------
  // frame states
  // ------------------------------------------------------------
  localparam [2:0] ST_PRE  = 3'h0;
  localparam [2:0] ST_HDR  = 3'h1;
  localparam [2:0] ST_TA   = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_RDAT = 3'h4;
  localparam [2:0] ST_END  = 3'h5;

  localparam [15:0] RST_INT_WORD = `RST_INT_CTRL_STAT;

  wire        mdc_rise;
  wire        mdc_fall;
  wire        mdio_s;

  reg  [2:0]  state_q;
  reg  [5:0]  cnt_q;
  reg  [13:0] hdr_q;
  reg  [15:0] shift_q;
  reg  [15:0] rd_q;
  reg         mine_q;
  reg         wr_stb_q;
  reg         rd_stb_q;

  reg  [7:0]  int_en_q;
  reg  [7:0]  int_stat_q;
  reg  [15:0] xover_q;
  reg  [15:0] ctrl_q;

  wire [1:0]  hdr_op;
  wire [4:0]  hdr_phy;
  wire [4:0]  hdr_reg;
  wire        clear_int;

  mdio_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .mdc      (mdc),
    .mdio_i   (mdio_i),
    .mdc_rise (mdc_rise),
    .mdc_fall (mdc_fall),
    .mdio_s   (mdio_s)
  );

  // header layout: st(2) op(2) phy(5) reg(5)
  assign hdr_op  = hdr_q[11:10];
  assign hdr_phy = hdr_q[9:5];
  assign hdr_reg = hdr_q[4:0];

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  function [15:0] read_word;
    input [4:0]  addr;
    input [7:0]  en;
    input [7:0]  st;
    input [15:0] xo;
    input [15:0] ct;
    input [6:0]  live;
    begin
      if (addr == `ADDR_INT_CTRL_STAT) begin
        read_word = {en, st};
      end else if (addr == `ADDR_XOVER_CTRL) begin
        read_word = xo;
      end else if (addr == `ADDR_PHY_CTRL_STAT) begin
        // R17 R18 R19 R20 R21 R22 live status bits
        read_word = (ct & `PHY_CTRL_RW_MASK) |
                    {9'h000, live[6:2], 1'b0, live[0]};
      end else begin
        read_word = 16'h0000;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // management frame engine
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q  <= ST_PRE;
      cnt_q    <= 6'h00;
      hdr_q    <= 14'h0000;
      shift_q  <= 16'h0000;
      rd_q     <= 16'h0000;
      mine_q   <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      mdio_o   <= 1'b1;
      mdio_oe  <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          ST_PRE: begin
            if (mdio_s) begin
              if (cnt_q != `MDIO_PRE_BITS)
                cnt_q <= cnt_q + 6'h01;
            end else if (cnt_q == `MDIO_PRE_BITS) begin
              // first start bit (0) seen after full preamble
              hdr_q   <= 14'h0000;
              cnt_q   <= 6'h01;
              state_q <= ST_HDR;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_q <= {hdr_q[12:0], mdio_s};
            if (cnt_q == 6'h0D) begin
              cnt_q   <= 6'h00;
              state_q <= ST_TA;
              // station address sits in bits 8:4 before the last shift
              mine_q  <= (hdr_q[8:4] == `MDIO_PHY_ADDR);
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          ST_TA: begin
            if (hdr_q[12] != 1'b1 || (hdr_op != `MDIO_OP_WRITE &&
                hdr_op != `MDIO_OP_READ)) begin
              cnt_q   <= 6'h00;
              state_q <= ST_PRE;
            end else if (cnt_q == 6'h01) begin
              cnt_q   <= 6'h00;
              state_q <= (hdr_op == `MDIO_OP_READ) ? ST_RDAT : ST_WDAT;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          ST_WDAT: begin
            shift_q <= {shift_q[14:0], mdio_s};
            if (cnt_q == 6'h0F) begin
              cnt_q    <= 6'h00;
              wr_stb_q <= mine_q;
              state_q  <= ST_END;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          ST_RDAT: begin
            if (cnt_q == 6'h0F) begin
              cnt_q   <= 6'h00;
              state_q <= ST_END;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          default: begin
            // this rise already carries the first preamble bit of the next frame
            cnt_q   <= {5'h00, mdio_s};
            state_q <= ST_PRE;
          end
        endcase
      end
      if (mdc_fall) begin
        if (state_q == ST_TA && mine_q && hdr_op == `MDIO_OP_READ) begin
          if (cnt_q == 6'h01) begin
            // second turnaround bit: drive zero, latch snapshot, clear events if the interrupt register is read
            // events of this cycle join the snapshot so the clear cannot lose them
            rd_q     <= read_word(hdr_reg, int_en_q, int_stat_q | event_pulse,
                                  xover_q, ctrl_q,
                                  {speed_1000, speed_100, speed_10, full_duplex,
                                   gig_master, 1'b0, link_check_fail});
            rd_stb_q <= 1'b1;
            mdio_o   <= 1'b0;
            mdio_oe  <= 1'b1;
          end
        end else if (state_q == ST_RDAT && mine_q) begin
          mdio_o  <= rd_q[15];
          rd_q    <= {rd_q[14:0], 1'b0};
          mdio_oe <= 1'b1;
        end else begin
          mdio_o  <= 1'b1;
          mdio_oe <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  assign clear_int = rd_stb_q && (hdr_reg == `ADDR_INT_CTRL_STAT);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_en_q   <= RST_INT_WORD[`INT_EN_MSB:`INT_EN_LSB];
      int_stat_q <= 8'h00;
      xover_q    <= `RST_XOVER_CTRL;
      ctrl_q     <= `RST_PHY_CTRL;
    end else begin
      if (wr_stb_q) begin
        if (hdr_reg == `ADDR_INT_CTRL_STAT) begin
          // R01 R02 R03 enable bits 15..8
          int_en_q <= shift_q[`INT_EN_MSB:`INT_EN_LSB];
        end else if (hdr_reg == `ADDR_XOVER_CTRL) begin
          xover_q <= shift_q;
        end else if (hdr_reg == `ADDR_PHY_CTRL_STAT) begin
          ctrl_q <= shift_q & `PHY_CTRL_RW_MASK;
        end
      end
      // R04 R05 R06 R07 R08 R09 R10 R11 set wins over read clear
      int_stat_q <= (clear_int ? 8'h00 : int_stat_q) | event_pulse;
    end
  end

  // ------------------------------------------------------------
  // outputs to the phy core
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      use_mdi         <= 1'b0;
      jabber_count_en <= 1'b1;
      int_pin         <= 1'b1;
    end else begin
      // R12 R13 R14 forced wiring only when auto is off
      use_mdi <= xover_q[`XOVER_SWAP_OFF_BIT] ? xover_q[`XOVER_WIRING_BIT]
                                               : auto_mdix_pair;
      // R16 jabber counter enable
      jabber_count_en <= ctrl_q[`CTRL_JABBER_EN_BIT];
      // R23 R15 level from enabled status, polarity from bit 14
      int_pin <= (|(int_stat_q & int_en_q)) ~^ ctrl_q[`CTRL_INT_LEVEL_BIT];
    end
  end

endmodule

//--- bench/phy_regs_checker.sv
// Purpose: pin-level checks on the register bank
// Assumes: mdc half period far above the pin synchroniser delay
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
module phy_regs_checker (
  input wire clk,
  input wire nrst,
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe,
  input wire jabber_count_en,
  input wire int_pin
);
  reg [9:0] oe_cnt_q;

  // cycles the device has held the data line
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      oe_cnt_q <= 10'h000;
    else if (mdio_oe)
      oe_cnt_q <= oe_cnt_q + 10'h001;
    else
      oe_cnt_q <= 10'h000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ta;
    $rose(mdio_oe) ##0 !mdio_o;
  endsequence
  sequence s_hold;
    mdio_oe [*8];
  endsequence

  AST_INT_RST: assert property ($rose(nrst) |-> int_pin)
    else $error("interrupt pin not idle high after reset");
  AST_JAB_RST: assert property ($rose(nrst) |-> jabber_count_en)
    else $error("jabber counter not enabled after reset");
  AST_TA_ZERO: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround not driven low");
  AST_TA_HOLD: assert property (s_ta |=> s_hold)
    else $error("read drive dropped early");
  AST_HOLD_LEN: assert property ($fell(mdio_oe) |-> oe_cnt_q > 10'h1F3 && oe_cnt_q < 10'h231)
    else $error("read drive length wrong");
  AST_O_STABLE: assert property (mdio_oe && $changed(mdio_o) |=> $stable(mdio_o) [*8])
    else $error("read data changed too soon");
  AST_OE_RISE: assert property ($rose(mdio_oe) |-> !mdc && $past(mdc, 2) == 1'b0)
    else $error("read drive not started after mdc fall");
  AST_JAB_QUIET: assert property ($changed(jabber_count_en) |-> !mdio_oe)
    else $error("control changed during a read");
endmodule

bind phy_irq_mdix_status_regs phy_regs_checker checker_inst (.clk(clk), .nrst(nrst), .mdc(mdc),
  .mdio_o(mdio_o), .mdio_oe(mdio_oe), .jabber_count_en(jabber_count_en), .int_pin(int_pin));

//--- bench/mdio_master.sv
// Purpose: station management controller model
// Assumes: pull-up on the data line
// Notes:   mdc half period is 16 clk cycles
`timescale 1ns/1ps
`include "phy_regs_map.vh"
module mdio_master (
  input  wire       clk,
  input  wire [4:0] phy_addr,
  input  wire mdio_o,
  input  wire mdio_oe,
  output reg  mdc,
  output wire mdio_i
);
  reg drv_q;
  reg en_q;

  // a released line floats high
  assign mdio_i = mdio_oe ? mdio_o : (en_q ? drv_q : 1'b1);

  initial begin
    mdc = 1'b0;
    drv_q = 1'b1;
    en_q = 1'b0;
  end

  task automatic bit_io(input b, input e, output s);
    begin
      drv_q <= b;
      en_q <= e;
      repeat (16) @(posedge clk);
      mdc <= 1'b1;
      s = mdio_i;
      repeat (16) @(posedge clk);
      mdc <= 1'b0;
    end
  endtask

  task automatic frame(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    reg [31:0] v;
    reg        s;
    integer    i;
    begin
      rd = 16'h0000;
      for (i = 0; i < 32; i = i + 1)
        bit_io(1'b1, 1'b1, s);
      v = {2'b01, op, phy_addr, ra, 2'b10, wd};
      for (i = 31; i >= 0; i = i - 1) begin
        bit_io(v[i], op == `MDIO_OP_WRITE || i > 17, s);
        if (i < 16)
          rd[i] = s;
      end
      en_q <= 1'b0;
      @(posedge clk);
    end
  endtask
endmodule

//--- bench/tb.sv
// Purpose: register bank tests over management frames
// Assumes: events are one-cycle pulses
// Notes:   roughly 60k clock cycles
`timescale 1ns/1ps
`include "phy_regs_map.vh"
module tb;
  reg        clk;
  reg        nrst;
  reg  [7:0] event_pulse;
  reg        auto_mdix_pair;
  reg  [5:0] st;
  reg  [4:0] station;
  wire       mdc;
  wire       mdio_i;
  wire       mdio_o;
  wire       mdio_oe;
  wire       use_mdi;
  wire       jabber_count_en;
  wire       int_pin;
  reg [15:0] rd;
  integer    failures = 0;
  integer    tests_run = 0;
  integer    cyc = 0;
  integer    i;

  phy_irq_mdix_status_regs phy_irq_mdix_status_regs_inst (.clk(clk), .nrst(nrst), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .event_pulse(event_pulse),
    .auto_mdix_pair(auto_mdix_pair), .speed_1000(st[5]), .speed_100(st[4]), .speed_10(st[3]),
    .full_duplex(st[2]), .gig_master(st[1]), .link_check_fail(st[0]), .use_mdi(use_mdi),
    .jabber_count_en(jabber_count_en), .int_pin(int_pin));
  mdio_master mdio_master_inst (.clk(clk), .phy_addr(station), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdc(mdc), .mdio_i(mdio_i));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  task check(input [23:0] name, input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // settle after the edge, compare, then realign to an edge
  task bchk(input [23:0] name, input seen, input exp);
    begin
      #1;
      check(name, {15'h0000, seen}, {15'h0000, exp});
      @(posedge clk);
    end
  endtask
  task wr(input [4:0] ra, input [15:0] d);
    mdio_master_inst.frame(`MDIO_OP_WRITE, ra, d, rd);
  endtask
  task rdchk(input [4:0] ra, input [15:0] exp);
    begin
      mdio_master_inst.frame(`MDIO_OP_READ, ra, 16'h0000, rd);
      check("reg", rd, exp);
    end
  endtask
  task pulse(input [7:0] e);
    begin
      event_pulse <= e;
      @(posedge clk);
      event_pulse <= 8'h00;
      repeat (4) @(posedge clk);
    end
  endtask

  initial begin
    nrst = 1'b0;
    event_pulse = 8'h00;
    auto_mdix_pair = 1'b1;
    st = 6'h00;
    station = `MDIO_PHY_ADDR;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    bchk("int", int_pin, 1'b1);
    bchk("jab", jabber_count_en, 1'b1);
    bchk("mdi", use_mdi, 1'b1);
    rdchk(`ADDR_INT_CTRL_STAT, 16'h0000);
    rdchk(`ADDR_XOVER_CTRL, 16'h0000);
    rdchk(`ADDR_PHY_CTRL_STAT, 16'h0200);
    rdchk(5'h10, 16'h0000);
    wr(`ADDR_INT_CTRL_STAT, 16'hFFFF);
    for (i = 0; i < 8; i = i + 1) begin
      pulse(8'h01 << i);
      bchk("int", int_pin, 1'b0);
      rdchk(`ADDR_INT_CTRL_STAT, 16'hFF00 | (16'h0001 << i));
      bchk("int", int_pin, 1'b1);
    end
    wr(`ADDR_INT_CTRL_STAT, 16'h0000);
    pulse(8'hFF);
    bchk("int", int_pin, 1'b1);
    rdchk(`ADDR_INT_CTRL_STAT, 16'h00FF);
    wr(`ADDR_PHY_CTRL_STAT, 16'h4200);
    bchk("int", int_pin, 1'b0);
    wr(`ADDR_INT_CTRL_STAT, 16'h0200);
    pulse(8'h02);
    bchk("int", int_pin, 1'b1);
    rdchk(`ADDR_PHY_CTRL_STAT, 16'h4200);
    wr(`ADDR_XOVER_CTRL, 16'h0080);
    auto_mdix_pair <= 1'b0;
    repeat (3) @(posedge clk);
    bchk("mdi", use_mdi, 1'b0);
    wr(`ADDR_XOVER_CTRL, 16'h00C0);
    bchk("mdi", use_mdi, 1'b1);
    auto_mdix_pair <= 1'b1;
    wr(`ADDR_XOVER_CTRL, 16'h0040);
    bchk("mdi", use_mdi, 1'b0);
    // frames for another station address are ignored
    station <= 5'h02;
    wr(`ADDR_XOVER_CTRL, 16'h0000);
    rdchk(`ADDR_XOVER_CTRL, 16'hFFFF);
    station <= `MDIO_PHY_ADDR;
    rdchk(`ADDR_XOVER_CTRL, 16'h0040);
    wr(`ADDR_PHY_CTRL_STAT, 16'h0000);
    bchk("jab", jabber_count_en, 1'b0);
    st <= 6'b100110;
    rdchk(`ADDR_PHY_CTRL_STAT, 16'h004C);
    st <= 6'b010001;
    rdchk(`ADDR_PHY_CTRL_STAT, 16'h0021);
    st <= 6'b001000;
    rdchk(`ADDR_PHY_CTRL_STAT, 16'h0010);
    // link check bit is not writable
    wr(`ADDR_PHY_CTRL_STAT, 16'hFFFF);
    rdchk(`ADDR_PHY_CTRL_STAT, 16'hF392);
    bchk("jab", jabber_count_en, 1'b1);
    bchk("int", int_pin, 1'b1);
    print_verdict;
  end
endmodule
